// ==== rtl/cycle_timer.sv ====
// one-shot down counter used for drain, csr read and divider latencies
// assumes i_start is only honoured while idle
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // control
    input  wire logic       i_start,
    input  wire logic [7:0] i_count,
    // status
    output logic            o_busy,
    output logic            o_done
);

    logic [7:0] count;
    logic [7:0] next_count;

    always_comb
    begin
        next_count = count;
        if (i_start && (count == 8'h00))
        begin
            next_count = i_count;
        end
        else if (count != 8'h00)
        begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count <= 8'h00;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign o_busy = (count != 8'h00);
    assign o_done = (count == 8'h01);

endmodule
`default_nettype wire

// ==== rtl/fp_control_pkg.sv ====
// constants, field layout and encodings for the floating-point control word block
// assumes a single core clock; counts are in core clock cycles
package fp_control_pkg;

    // ------------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------------
    localparam int          PREC_LSB        = 8;
    localparam int          PREC_MSB        = 9;
    localparam int          RC_LSB          = 10;
    localparam int          RC_MSB          = 11;
    localparam int          IC_BIT          = 12;
    localparam logic [15:0] FAST_SWITCH_MASK = 16'h1F00;
    localparam logic [15:0] CW_RESET        = 16'h037F;

    localparam logic [1:0]  PREC_SINGLE     = 2'h0;
    localparam logic [1:0]  PREC_DOUBLE     = 2'h2;
    localparam logic [1:0]  RC_TOWARD_ZERO  = 2'h3;

    // ------------------------------------------------------------------
    // simd control/status word layout
    // ------------------------------------------------------------------
    localparam int          SIMD_DENORM_BIT = 6;
    localparam int          SIMD_FLUSH_BIT  = 15;
    localparam logic [31:0] SIMD_CSR_RESET  = 32'h00001F80;

    // ------------------------------------------------------------------
    // timing counts (pipeline depth and unit latencies)
    // ------------------------------------------------------------------
    localparam logic [7:0]  DRAIN_CYCLES      = 8'h14;
    localparam logic [7:0]  SIMD_WRITE_CYCLES = 8'h14;
    localparam logic [7:0]  SIMD_READ_CYCLES  = 8'h06;
    localparam logic [7:0]  DIV_SINGLE_CYCLES = 8'h0A;
    localparam logic [7:0]  DIV_DOUBLE_CYCLES = 8'h11;
    localparam logic [7:0]  DIV_EXT_CYCLES    = 8'h17;

    // ------------------------------------------------------------------
    // operation encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_INTEGER_STORE             = 2'h0,
        OP_TRUNCATING_SINGLE_CONVERT = 2'h1,
        OP_TRUNCATING_DOUBLE_CONVERT = 2'h3
    } convert_op_t;

    typedef enum logic [1:0] {
        ACCESS_8  = 2'h0,
        ACCESS_16 = 2'h1,
        ACCESS_32 = 2'h3
    } access_size_t;

endpackage

// ==== rtl/fp_control_word_fast_switch.sv ====
// floating-point control word with two-value fast switch, simd csr and mode helpers
// assumes the instruction stream holds each request valid until its ready is seen
//
// Behaviour
// - precision bits 9:8, rounding bits 11:10, infinity bit 12 of control word.
// - alternating two values differing only in bits 12:8 loads fast.
// - a change outside bits 12:8 takes the slow draining path.
// - cycling three or more distinct values makes every load slow.
// - switching to a new pair costs only during changeover, then fast again.
// - slow path stalls for about the pipeline depth.
// - simd csr read has long latency; write serialises; no fast path.
// - one simd mode set serves single and double precision alike.
// - truncating converts always round toward zero.
// - integer store rounds per control word rounding field.
// - stored control word forwards only to 16-bit loads; others stall.
// - divider faster at single than double, double faster than extended.
// - flush-underflow-to-zero gives signed zero for underflowing results.
// - denormal-inputs-as-zero turns denormal operands into signed zero.
`timescale 1ns/1ps
`default_nettype none
module fp_control_word_fast_switch
    import fp_control_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // control word load
    input  wire logic         i_cw_load_valid,
    input  wire logic [15:0]  i_cw_load_data,
    output logic              o_cw_ready,
    output logic              o_cw_load_done,
    output logic              o_cw_load_slow,
    output logic [15:0]       o_fpu_control_word,
    output logic [1:0]        o_precision_control_field,
    output logic [1:0]        o_rounding_control_field,
    output logic              o_infinity_control,
    // control word store and forwarding
    input  wire logic         i_cw_store_valid,
    input  wire logic         i_fwd_load_valid,
    input  wire logic [1:0]   i_fwd_load_size,
    output logic [15:0]       o_fwd_data,
    output logic              o_fwd_valid,
    output logic              o_fwd_stall,
    // simd control/status word
    input  wire logic         i_simd_write_valid,
    input  wire logic [31:0]  i_simd_write_data,
    output logic              o_simd_write_done,
    input  wire logic         i_simd_read_valid,
    output logic              o_simd_read_ready,
    output logic [31:0]       o_simd_read_data,
    output logic              o_simd_read_valid,
    output logic              o_flush_underflow_to_zero,
    output logic              o_denormal_inputs_as_zero,
    // convert rounding
    input  wire logic         i_cvt_valid,
    input  wire logic [1:0]   i_cvt_op,
    output logic [1:0]        o_round_mode,
    output logic              o_round_valid,
    // divider timing
    input  wire logic         i_div_start,
    output logic              o_div_ready,
    output logic              o_div_done,
    // simd result and operand filtering
    input  wire logic         i_simd_valid,
    input  wire logic         i_simd_is_double,
    input  wire logic         i_result_underflow,
    input  wire logic [63:0]  i_simd_result,
    input  wire logic [63:0]  i_simd_operand,
    output logic [63:0]       o_simd_result,
    output logic [63:0]       o_simd_operand,
    output logic              o_simd_out_valid
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [15:0] cw;
    logic [15:0] hist_recent;
    logic [15:0] hist_older;
    logic        fast_done;
    logic        owner_cw;
    logic [31:0] simd_csr;
    logic [15:0] next_cw;
    logic [15:0] next_hist_recent;
    logic [15:0] next_hist_older;
    logic        next_fast_done;
    logic        next_owner_cw;
    logic [31:0] next_simd_csr;

    logic        drain_busy;
    logic        drain_done;
    logic        drain_start;
    logic [7:0]  drain_count;
    logic        read_busy;
    logic        read_done;
    logic        div_busy;
    logic [7:0]  div_count;

    logic        cw_accept;
    logic        simd_write_accept;
    logic        outside_same;
    logic        in_history;
    logic        fast_load;

    // ------------------------------------------------------------------
    // control word load path
    // ------------------------------------------------------------------
    assign o_cw_ready        = !drain_busy;
    assign cw_accept         = i_cw_load_valid && o_cw_ready;
    assign simd_write_accept = i_simd_write_valid && o_cw_ready && !i_cw_load_valid;
    assign outside_same      = ((i_cw_load_data ^ cw) & ~FAST_SWITCH_MASK) == 16'h0000;
    assign in_history        = (i_cw_load_data == hist_recent) ||
                               (i_cw_load_data == hist_older);
    // a third distinct value misses both history slots and drains every time
    assign fast_load         = outside_same && in_history;

    always_comb
    begin
        next_cw          = cw;
        next_hist_recent = hist_recent;
        next_hist_older  = hist_older;
        next_fast_done   = 1'b0;
        next_owner_cw    = owner_cw;
        next_simd_csr    = simd_csr;
        drain_start      = 1'b0;
        drain_count      = DRAIN_CYCLES;
        if (cw_accept)
        begin
            next_cw = i_cw_load_data;
            if (i_cw_load_data != hist_recent)
            begin
                next_hist_recent = i_cw_load_data;
                next_hist_older  = hist_recent;
            end
            if (fast_load)
            begin
                next_fast_done = 1'b1;
            end
            else
            begin
                drain_start    = 1'b1;
                next_owner_cw = 1'b1;
            end
        end
        else if (simd_write_accept)
        begin
            // no history for the simd word: every write drains
            next_simd_csr  = i_simd_write_data;
            drain_start    = 1'b1;
            drain_count    = SIMD_WRITE_CYCLES;
            next_owner_cw  = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cw          <= CW_RESET;
            hist_recent <= CW_RESET;
            hist_older  <= CW_RESET;
            fast_done   <= 1'b0;
            owner_cw    <= 1'b0;
            simd_csr    <= SIMD_CSR_RESET;
        end
        else
        begin
            cw          <= next_cw;
            hist_recent <= next_hist_recent;
            hist_older  <= next_hist_older;
            fast_done   <= next_fast_done;
            owner_cw    <= next_owner_cw;
            simd_csr    <= next_simd_csr;
        end
    end

    cycle_timer u_drain
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (drain_start),
        .i_count (drain_count),
        .o_busy  (drain_busy),
        .o_done  (drain_done)
    );

    assign o_cw_load_done            = fast_done || (drain_done && owner_cw);
    assign o_cw_load_slow            = drain_done && owner_cw;
    assign o_simd_write_done         = drain_done && !owner_cw;
    assign o_fpu_control_word        = cw;
    assign o_precision_control_field = cw[PREC_MSB:PREC_LSB];
    assign o_rounding_control_field  = cw[RC_MSB:RC_LSB];
    assign o_infinity_control        = cw[IC_BIT];
    assign o_flush_underflow_to_zero = simd_csr[SIMD_FLUSH_BIT];
    assign o_denormal_inputs_as_zero = simd_csr[SIMD_DENORM_BIT];

    // ------------------------------------------------------------------
    // simd csr read, convert rounding, forwarding, filtering
    // ------------------------------------------------------------------
    logic [31:0] rd_data;
    logic        rd_valid;
    logic [1:0]  rmode;
    logic        rvalid;
    logic [15:0] stored_word;
    logic [15:0] fwd_data;
    logic        fwd_valid;
    logic        fwd_stall;
    logic [63:0] res_q;
    logic [63:0] opd_q;
    logic        out_valid;
    logic [31:0] next_rd_data;
    logic        next_rd_valid;
    logic [1:0]  next_rmode;
    logic        next_rvalid;
    logic [15:0] next_stored_word;
    logic [15:0] next_fwd_data;
    logic        next_fwd_valid;
    logic        next_fwd_stall;
    logic [63:0] next_res_q;
    logic [63:0] next_opd_q;
    logic        next_out_valid;
    logic        opd_denormal;
    logic [63:0] signed_zero_res;
    logic [63:0] signed_zero_opd;

    assign o_simd_read_ready = !read_busy;

    cycle_timer u_read
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (i_simd_read_valid),
        .i_count (SIMD_READ_CYCLES),
        .o_busy  (read_busy),
        .o_done  (read_done)
    );

    // one mode set; only the denormal test and the zero's format follow the element width
    assign opd_denormal    = i_simd_is_double ?
                             ((i_simd_operand[62:52] == 11'h000) && (i_simd_operand[51:0] != 52'h0)) :
                             ((i_simd_operand[30:23] == 8'h00) && (i_simd_operand[22:0] != 23'h0));
    assign signed_zero_res = i_simd_is_double ? {i_simd_result[63], 63'h0} :
                             {32'h0, i_simd_result[31], 31'h0};
    assign signed_zero_opd = i_simd_is_double ? {i_simd_operand[63], 63'h0} :
                             {32'h0, i_simd_operand[31], 31'h0};

    always_comb
    begin
        next_rd_data     = rd_data;
        next_rd_valid    = read_done;
        next_rmode       = rmode;
        next_rvalid      = i_cvt_valid;
        next_stored_word = stored_word;
        next_fwd_data    = fwd_data;
        next_fwd_valid   = 1'b0;
        next_fwd_stall   = 1'b0;
        next_res_q       = res_q;
        next_opd_q       = opd_q;
        next_out_valid   = i_simd_valid;
        if (read_done)
        begin
            next_rd_data = simd_csr;
        end
        if (i_cvt_valid)
        begin
            if (i_cvt_op == OP_INTEGER_STORE)
            begin
                next_rmode = cw[RC_MSB:RC_LSB];
            end
            else
            begin
                next_rmode = RC_TOWARD_ZERO;
            end
        end
        if (i_cw_store_valid)
        begin
            next_stored_word = cw;
        end
        if (i_fwd_load_valid)
        begin
            if (i_fwd_load_size == ACCESS_16)
            begin
                next_fwd_data  = stored_word;
                next_fwd_valid = 1'b1;
            end
            else
            begin
                next_fwd_stall = 1'b1;
            end
        end
        if (i_simd_valid)
        begin
            next_res_q = (o_flush_underflow_to_zero && i_result_underflow) ?
                         signed_zero_res : i_simd_result;
            next_opd_q = (o_denormal_inputs_as_zero && opd_denormal) ?
                         signed_zero_opd : i_simd_operand;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_data     <= 32'h00000000;
            rd_valid    <= 1'b0;
            rmode       <= 2'h0;
            rvalid      <= 1'b0;
            stored_word <= 16'h0000;
            fwd_data    <= 16'h0000;
            fwd_valid   <= 1'b0;
            fwd_stall   <= 1'b0;
            res_q       <= 64'h0;
            opd_q       <= 64'h0;
            out_valid   <= 1'b0;
        end
        else
        begin
            rd_data     <= next_rd_data;
            rd_valid    <= next_rd_valid;
            rmode       <= next_rmode;
            rvalid      <= next_rvalid;
            stored_word <= next_stored_word;
            fwd_data    <= next_fwd_data;
            fwd_valid   <= next_fwd_valid;
            fwd_stall   <= next_fwd_stall;
            res_q       <= next_res_q;
            opd_q       <= next_opd_q;
            out_valid   <= next_out_valid;
        end
    end

    assign o_simd_read_data  = rd_data;
    assign o_simd_read_valid = rd_valid;
    assign o_round_mode      = rmode;
    assign o_round_valid     = rvalid;
    assign o_fwd_data        = fwd_data;
    assign o_fwd_valid       = fwd_valid;
    assign o_fwd_stall       = fwd_stall;
    assign o_simd_result     = res_q;
    assign o_simd_operand    = opd_q;
    assign o_simd_out_valid  = out_valid;

    // ------------------------------------------------------------------
    // divider latency by precision
    // ------------------------------------------------------------------
    // reserved precision code runs at the extended rate, the safe worst case
    assign div_count   = (cw[PREC_MSB:PREC_LSB] == PREC_SINGLE) ? DIV_SINGLE_CYCLES :
                         (cw[PREC_MSB:PREC_LSB] == PREC_DOUBLE) ? DIV_DOUBLE_CYCLES :
                         DIV_EXT_CYCLES;
    assign o_div_ready = !div_busy;

    cycle_timer u_div
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (i_div_start),
        .i_count (div_count),
        .o_busy  (div_busy),
        .o_done  (o_div_done)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    localparam int DRAIN_WAIT = int'(DRAIN_CYCLES);
    localparam int READ_WAIT  = int'(SIMD_READ_CYCLES) + 1;
    localparam int DIVS_WAIT  = int'(DIV_SINGLE_CYCLES);

    AST_FIELDS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cw_accept |=> o_rounding_control_field == $past(i_cw_load_data[RC_MSB:RC_LSB]))
        else $error("rounding field not taken from loaded word");
    AST_FAST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cw_accept && fast_load) |=> (o_cw_load_done && !o_cw_load_slow && o_cw_ready))
        else $error("fast load did not finish next cycle");
    AST_OUTSIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cw_accept && !outside_same) |=> !o_cw_ready)
        else $error("change outside fast bits did not drain");
    AST_THIRD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cw_accept && !in_history) |=> (!o_cw_ready)[*8])
        else $error("third value escaped the slow path");
    AST_HIST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cw_accept && i_cw_load_data != hist_recent) |=>
        (hist_recent == $past(i_cw_load_data) && hist_older == $past(hist_recent)))
        else $error("history not shifted on new value");
    AST_DRAIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cw_accept && !fast_load) |-> ##[DRAIN_WAIT:DRAIN_WAIT] (o_cw_load_done && o_cw_load_slow))
        else $error("slow load drain length wrong");
    AST_CSR_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_simd_read_valid && o_simd_read_ready) |-> ##[READ_WAIT:READ_WAIT] o_simd_read_valid)
        else $error("simd csr read latency wrong");
    AST_CSR_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        simd_write_accept |=> (!o_cw_ready && o_flush_underflow_to_zero == $past(i_simd_write_data[SIMD_FLUSH_BIT])))
        else $error("simd csr write did not serialise");
    AST_TRUNC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_cvt_valid && i_cvt_op != OP_INTEGER_STORE) |=> (o_round_mode == RC_TOWARD_ZERO && o_round_valid))
        else $error("truncating convert not rounding to zero");
    AST_FIST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_cvt_valid && i_cvt_op == OP_INTEGER_STORE) |=> o_round_mode == $past(o_rounding_control_field))
        else $error("integer store ignored rounding field");
    AST_FWD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_fwd_load_valid && i_fwd_load_size != ACCESS_16) |=> (o_fwd_stall && !o_fwd_valid))
        else $error("size mismatch forwarded");
    AST_DIV: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_div_start && o_div_ready && o_precision_control_field == PREC_SINGLE) |-> ##[DIVS_WAIT:DIVS_WAIT] o_div_done)
        else $error("single precision divide latency wrong");
    AST_FLUSH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_simd_valid && i_result_underflow && o_flush_underflow_to_zero && i_simd_is_double) |=>
        o_simd_result == {$past(i_simd_result[63]), 63'h0})
        else $error("underflow not flushed to signed zero");
    AST_DENORM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_simd_valid && opd_denormal && o_denormal_inputs_as_zero && !i_simd_is_double) |=>
        o_simd_operand == {32'h0, $past(i_simd_operand[31]), 31'h0})
        else $error("denormal operand not zeroed");

endmodule
`default_nettype wire

// ==== test/fp_control_word_fast_switch_tb_top.sv ====
// self-checking bench for the control word fast switch block
// assumes the answer delays of the design contract; done pulses are sampled on falling edges
`timescale 1ns/1ps
`default_nettype none
module fp_control_word_fast_switch_tb_top;
    import fp_control_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        i_clk = 0, i_rst_n = 0, i_cw_load_valid = 0, i_cw_store_valid = 0, i_fwd_load_valid = 0;
    logic        i_simd_write_valid = 0, i_simd_read_valid = 0, i_cvt_valid = 0, i_div_start = 0;
    logic        i_simd_valid = 0, i_simd_is_double = 0, i_result_underflow = 0;
    logic [15:0] i_cw_load_data = 16'h0000;
    logic [1:0]  i_fwd_load_size = 2'h0, i_cvt_op = 2'h0;
    logic [31:0] i_simd_write_data = 32'h00000000;
    logic [63:0] i_simd_result = 64'h0, i_simd_operand = 64'h0;
    logic        o_cw_ready, o_cw_load_done, o_cw_load_slow, o_infinity_control, o_fwd_valid, o_fwd_stall;
    logic        o_simd_write_done, o_simd_read_ready, o_simd_read_valid, o_flush_underflow_to_zero;
    logic        o_denormal_inputs_as_zero, o_round_valid, o_div_ready, o_div_done, o_simd_out_valid;
    logic [15:0] o_fpu_control_word, o_fwd_data;
    logic [1:0]  o_precision_control_field, o_rounding_control_field, o_round_mode;
    logic [31:0] o_simd_read_data;
    logic [63:0] o_simd_result, o_simd_operand;
    int          mismatches = 0, cmp_count = 0, cyc = 0;
    logic [15:0] trio [3] = '{16'h0B7F, 16'h037F, 16'h0F7F};

    fp_control_word_fast_switch fp_control_word_fast_switch_inst (.*);

    initial
    begin
        forever #10 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("TB: %0d mismatches in %0d compares", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // sel 0 load, 1 simd write, 2 simd read, 3 divide; counts falling edges from accept to answer
    task automatic op(input int sel, input int exp_n);
        int n;
        n = 0;
        @(posedge i_clk);
        case (sel)
            0: i_cw_load_valid <= 1'b1;
            1: i_simd_write_valid <= 1'b1;
            2: i_simd_read_valid <= 1'b1;
            default: i_div_start <= 1'b1;
        endcase
        @(negedge i_clk);
        while ((sel == 2 ? o_simd_read_ready : sel == 3 ? o_div_ready : o_cw_ready) !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        {i_cw_load_valid, i_simd_write_valid, i_simd_read_valid, i_div_start} <= 4'h0;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while ((sel == 0 ? o_cw_load_done : sel == 1 ? o_simd_write_done : sel == 2 ? o_simd_read_valid
                : o_div_done) !== 1'b1 && n < 40);
        check(n, exp_n);
        if (sel >= 2) check(sel == 2 ? o_simd_read_ready : o_div_ready, sel == 2);
    endtask

    task automatic cw_load(input logic [15:0] d, input logic slow);
        @(posedge i_clk);
        i_cw_load_data <= d;
        op(0, slow ? 20 : 1);
        check(o_cw_load_slow, slow);
        check(o_cw_ready, !slow);
        check({o_infinity_control, o_rounding_control_field, o_precision_control_field, o_fpu_control_word}, {d[12:8], d});
    endtask

    task automatic cvt(input logic [1:0] code, input logic [1:0] exp);
        @(posedge i_clk);
        {i_cvt_valid, i_cvt_op} <= {1'b1, code};
        @(posedge i_clk);
        i_cvt_valid <= 1'b0;
        @(negedge i_clk);
        check({o_round_valid, o_round_mode}, {1'b1, exp});
    endtask

    task automatic fwd(input logic [1:0] size);
        @(posedge i_clk);
        i_cw_store_valid <= 1'b1;
        @(posedge i_clk);
        {i_cw_store_valid, i_fwd_load_valid, i_fwd_load_size} <= {2'b01, size};
        @(posedge i_clk);
        i_fwd_load_valid <= 1'b0;
        @(negedge i_clk);
        check({o_fwd_valid, o_fwd_stall}, (size == 2'h1) ? 2'b10 : 2'b01);
        if (size == 2'h1) check(o_fwd_data, 16'h0B7F);
    endtask

    task automatic filt(input logic dbl, input logic [63:0] val, input logic [63:0] exp, input logic [63:0] msk);
        @(posedge i_clk);
        {i_simd_valid, i_simd_is_double, i_result_underflow, i_simd_result, i_simd_operand} <= {1'b1, dbl, 1'b1, val, val};
        @(posedge i_clk);
        i_simd_valid <= 1'b0;
        @(negedge i_clk);
        check(o_simd_out_valid, 1'b1);
        check(o_simd_result & msk, exp);
        check(o_simd_operand & msk, exp);
    endtask
    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        check(o_fpu_control_word, CW_RESET);
        cvt(OP_INTEGER_STORE, 2'h0);
        cw_load(16'h037F, 1'b0);
        cw_load(16'h0F7F, 1'b1);
        cw_load(16'h037F, 1'b0);
        cw_load(16'h0F7F, 1'b0);
        for (int i = 0; i < 6; i++) cw_load(trio[i % 3], 1'b1);
        for (int i = 0; i < 4; i++) cw_load(i[0] ? 16'h0A7F : 16'h027F, i < 2);
        cw_load(16'h0A7E, 1'b1);
        cw_load(16'h0A7F, 1'b1);
        op(3, 17);
        cw_load(16'h087F, 1'b1);
        op(3, 10);
        cw_load(16'h0B7F, 1'b1);
        op(3, 23);
        cvt(OP_INTEGER_STORE, 2'h2);
        cvt(OP_TRUNCATING_SINGLE_CONVERT, RC_TOWARD_ZERO);
        cvt(OP_TRUNCATING_DOUBLE_CONVERT, RC_TOWARD_ZERO);
        for (int s = 0; s < 4; s++) if (s != 2) fwd(s[1:0]);
        // modes still off: neither result nor operand may be touched
        filt(1'b0, 64'h0000000080000123, 64'h0000000080000123, 64'h00000000FFFFFFFF);
        @(posedge i_clk);
        i_simd_write_data <= 32'h00009FC0;
        op(1, 20);
        check({o_flush_underflow_to_zero, o_denormal_inputs_as_zero}, 2'b11);
        op(2, 7);
        check(o_simd_read_data, 32'h00009FC0);
        filt(1'b0, 64'h0000000080000123, 64'h0000000080000000, 64'h00000000FFFFFFFF);
        filt(1'b1, 64'h8000000000000005, 64'h8000000000000000, 64'hFFFFFFFFFFFFFFFF);
        print_verdict();
    end
endmodule
`default_nettype wire
